// ===== dv/elk_checker.sv
// assertion checker for the eprom lock block
`timescale 1ns/1ps
`include "elk_params.svh"
module elk_checker import elk_pkg::*; #(
  parameter logic [7:0] SIG_BYTE0 = 8'ha5,
  parameter logic [7:0] SIG_BYTE1 = 8'h5a,
  parameter logic [7:0] SIG_BYTE2 = 8'h3c
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire elk_pgm_in_type PGM_IN,
  input wire logic [7:0] PGM_DATA_O,
  input wire logic PGM_DATA_OE,
  input wire logic EXTERNAL_ACCESS_PIN,
  input wire elk_cpu_req_type CPU_REQ,
  input wire elk_cpu_gnt_type CPU_GNT
);
  // ==========================================================
  // helper logic
  logic [2:0] up_q;
  logic [3:0] quiet_q;
  logic sig_sel;
  logic [7:0] sig_exp;
  assign sig_sel = PGM_IN.program_strobe_rst && !PGM_IN.psen_n && PGM_IN.ctl == `ELK_CTL_SIGNATURE &&
    (PGM_IN.addr == `ELK_SIG_LOC0 || PGM_IN.addr == `ELK_SIG_LOC1 || PGM_IN.addr == `ELK_SIG_LOC2);
  assign sig_exp = PGM_IN.addr == `ELK_SIG_LOC0 ? SIG_BYTE0 : PGM_IN.addr == `ELK_SIG_LOC1 ? SIG_BYTE1 : SIG_BYTE2;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN || $changed(EXTERNAL_ACCESS_PIN)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  AST_SIG_BYTE: assert property (
    (sig_sel && $stable(PGM_IN))[*5] |-> PGM_DATA_OE && PGM_DATA_O == sig_exp)
    else $error("signature byte wrong");
  AST_OE_ON: assert property (
    $fell(PGM_IN.ctl[3]) && sig_sel ##1 (sig_sel && $stable(PGM_IN))[*3] |-> ##[0:44] PGM_DATA_OE)
    else $error("data not driven after enable");
  AST_OE_OFF: assert property (
    $rose(PGM_IN.ctl[3]) |-> ##[1:48] !PGM_DATA_OE)
    else $error("data not released after enable withdrawn");
  AST_TABLE_OK: assert property (
    up_q == 3'h7 && !(CPU_REQ.table_read && CPU_REQ.from_external) |=> CPU_GNT.int_read_ok)
    else $error("internal read refused without cause");
  AST_GNT_STEADY: assert property (
    up_q == 3'h7 && $stable(CPU_REQ) |=> $stable(CPU_GNT.int_read_ok) && $stable(CPU_GNT.ext_exec_ok))
    else $error("grant changed without request change");
  AST_EA_STEADY: assert property (
    up_q == 3'h7 && quiet_q == 4'hf |-> $stable(CPU_GNT.external_access))
    else $error("external access moved while pin quiet");
  AST_RD_ANSWER: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  AST_RD_HOLD: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before ready");
endmodule

bind elk_top elk_checker #(.SIG_BYTE0(SIG_BYTE0), .SIG_BYTE1(SIG_BYTE1), .SIG_BYTE2(SIG_BYTE2)) u_chk (
  .CLK(CLK), .RESETN(RESETN), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PGM_IN(PGM_IN),
  .PGM_DATA_O(PGM_DATA_O), .PGM_DATA_OE(PGM_DATA_OE), .EXTERNAL_ACCESS_PIN(EXTERNAL_ACCESS_PIN),
  .CPU_REQ(CPU_REQ), .CPU_GNT(CPU_GNT));

// ===== dv/elk_program_strobe_model.sv
// programmer model that drives the programming pins
`timescale 1ns/1ps
module elk_program_strobe_model import elk_pkg::*; #(
  parameter int HOLD_CYC = 48,
  parameter int WIDTH_CYC = 50,
  parameter int GAP_CYC = 2500
) (
  input wire logic CLK,
  output elk_pgm_in_type PGM
);
  // ==========================================================
  // idle levels: not in programming mode, strobe high
  initial begin
    PGM = '{14'h0, 8'h00, 5'h1f, 1'b0, 1'b1, 1'b0, 1'b1};
  end

  // ==========================================================
  // select a mode and address, data lines driven with the inverse of their last value
  task automatic drive(input logic [4:0] c, input logic [13:0] a);
    @(posedge CLK);
    PGM <= '{a, ~PGM.data, c, 1'b1, 1'b0, 1'b0, 1'b1};
  endtask

  // ==========================================================
  // programming burst: set-up, strobe pulses, hold
  task automatic burn(input logic [4:0] c, input logic [13:0] a, input logic [7:0] d, input int n);
    @(posedge CLK);
    PGM <= '{a, d, c, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (HOLD_CYC) @(posedge CLK);
    PGM.vpp_high <= 1'b1;
    repeat (HOLD_CYC) @(posedge CLK);
    for (int i = 0; i < n; i++) begin
      PGM.program_strobe_n <= 1'b0;
      repeat (WIDTH_CYC) @(posedge CLK);
      PGM.program_strobe_n <= 1'b1;
      repeat (GAP_CYC) @(posedge CLK);
    end
    PGM.vpp_high <= 1'b0;
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the eprom lock block
`timescale 1ns/1ps
`include "elk_params.svh"
module tb import elk_pkg::*; ;
  localparam logic [7:0] SIG0 = 8'h96; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h69; // arbitrary value
  localparam logic [7:0] SIG2 = 8'hc3; // arbitrary value
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ea_pin = 1'b1;
  logic [31:0] wdata = 32'h0;
  elk_cpu_req_type cpu_req = '0;
  logic awready, wready, bvalid, arready, rvalid, oe;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0] dout;
  elk_pgm_in_type pgm;
  elk_cpu_gnt_type gnt;
  int n_mismatch = 0;
  int checked = 0;

  initial forever #2 CLK = ~CLK;

  elk_top #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) uut (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PGM_IN(pgm), .PGM_DATA_O(dout), .PGM_DATA_OE(oe),
    .EXTERNAL_ACCESS_PIN(ea_pin), .CPU_REQ(cpu_req), .CPU_GNT(gnt));
  // strobe gap shortened to keep the run short
  elk_program_strobe_model #(.GAP_CYC(200)) prg (.CLK(CLK), .PGM(pgm));

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      if (arready) arvalid <= 1'b0;
      if (k == 1) rready <= 1'b1;
      k++;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    chk("rdata", e, rd & m);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask
  task automatic vchk(input logic [4:0] c, input logic [13:0] a, input logic oe_e, input logic [7:0] e);
    prg.drive(5'h1f, a);
    prg.drive(c, a);
    repeat (`ELK_VERIFY_MAX_CYC) @(posedge CLK);
    chk("data_oe", {31'h0, oe_e}, {31'h0, oe});
    if (oe_e) chk("data_out", {24'h0, e}, {24'h0, dout});
  endtask
  task automatic cchk(input logic [2:0] q, input logic [2:0] e);
    cpu_req <= q;
    repeat (4) @(posedge CLK);
    chk("cpu_gnt", {29'h0, e}, {29'h0, gnt});
  endtask
  task automatic do_reset();
    RESETN <= 1'b0;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLK);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    do_reset();
    rchk(`ELK_REG_CTRL, 32'h3, `ELK_CTRL_RESET, 2'h0);
    rchk(`ELK_REG_STATUS, 32'h3, 32'h0, 2'h0);
    rchk(8'h10, 32'hffffffff, 32'h0, 2'h2);
    wr(8'h10, 32'h0, 2'h2);
    wr(`ELK_REG_STATUS, 32'h3, 2'h2);
    $display("test registers done");
    vchk(`ELK_CTL_SIGNATURE, `ELK_SIG_LOC0, 1'b1, SIG0);
    vchk(`ELK_CTL_SIGNATURE, `ELK_SIG_LOC1, 1'b1, SIG1);
    vchk(`ELK_CTL_SIGNATURE, `ELK_SIG_LOC2, 1'b1, SIG2);
    $display("test signature done");
    cchk(3'b111, 3'b111);
    ea_pin <= 1'b0;
    cchk(3'b111, 3'b110);
    ea_pin <= 1'b1;
    vchk(`ELK_CTL_VERIFY, 14'h0123, 1'b1, 8'hff);
    prg.burn(`ELK_CTL_PROGRAM_STROBE_CODE, 14'h0045, 8'h3c, 5);
    vchk(`ELK_CTL_VERIFY, 14'h0045, 1'b1, 8'h3c);
    prg.burn(`ELK_CTL_PROGRAM_STROBE_ENC, 14'h0005, 8'h0f, 25);
    vchk(`ELK_CTL_VERIFY, 14'h0045, 1'b1, 8'hcc);
    vchk(`ELK_CTL_VERIFY, 14'h0085, 1'b1, 8'h0f);
    vchk(`ELK_CTL_VERIFY, 14'h0046, 1'b1, 8'hff);
    rchk(`ELK_REG_PULSES, 32'hff, 32'd30, 2'h0);
    $display("test unlocked done");
    prg.burn(`ELK_CTL_PROGRAM_STROBE_LB1, 14'h0000, 8'h00, 25);
    do_reset();
    rchk(`ELK_REG_STATUS, 32'h3, 32'h1, 2'h0);
    ea_pin <= 1'b0;
    cchk(3'b111, 3'b011);
    prg.burn(`ELK_CTL_PROGRAM_STROBE_CODE, 14'h0045, 8'h00, 5);
    vchk(`ELK_CTL_VERIFY, 14'h0045, 1'b1, 8'hcc);
    rchk(`ELK_REG_FLAGS, 32'h1, 32'h1, 2'h0);
    wr(`ELK_REG_FLAGS, 32'h1, 2'h0);
    rchk(`ELK_REG_FLAGS, 32'h1, 32'h0, 2'h0);
    ea_pin <= 1'b1;
    $display("test level two done");
    prg.burn(`ELK_CTL_PROGRAM_STROBE_LB2, 14'h0000, 8'h00, 25);
    do_reset();
    rchk(`ELK_REG_STATUS, 32'h3, 32'h2, 2'h0);
    vchk(`ELK_CTL_VERIFY, 14'h0045, 1'b0, 8'h00);
    rchk(`ELK_REG_FLAGS, 32'h2, 32'h2, 2'h0);
    cchk(3'b111, 3'b011);
    $display("test level three done");
    prg.burn(`ELK_CTL_PROGRAM_STROBE_LB3, 14'h0000, 8'h00, 25);
    do_reset();
    rchk(`ELK_REG_STATUS, 32'h3, 32'h3, 2'h0);
    cchk(3'b111, 3'b001);
    rchk(`ELK_REG_FLAGS, 32'hc, 32'hc, 2'h0);
    $display("test level four done");
    wr(`ELK_REG_CTRL, 32'h3, 2'h0);
    rchk(`ELK_REG_CTRL, 32'h3, 32'h3, 2'h0);
    repeat (16400) @(posedge CLK);
    rchk(`ELK_REG_STATUS, 32'h11c, 32'h0, 2'h0);
    do_reset();
    rchk(`ELK_REG_STATUS, 32'h3, 32'h0, 2'h0);
    vchk(`ELK_CTL_VERIFY, 14'h0045, 1'b1, 8'hff);
    $display("test erase done");
    final_report();
  end

  initial begin
    repeat (80000) @(posedge CLK);
    n_mismatch++;
    final_report();
  end
endmodule

// ===== hdl/elk_level_dec.sv
// lock bit decoder: protection level and undefined flag
`timescale 1ns/1ps
module elk_level_dec import elk_pkg::*; (
  input wire logic [2:0] lock_program_strobe,
  output elk_level_type level,
  output logic undefined
);

  // ==========================================================
  // decode, undefined patterns fall to the strictest level
  always_comb begin
    undefined = 1'b0;
    case (lock_program_strobe)
      3'h0: level = LVL_NONE;
      3'h1: level = LVL_BASIC;
      3'h3: level = LVL_NOVERIFY;
      3'h7: level = LVL_NOEXT;
      default: begin
        level = LVL_NOEXT;
        undefined = 1'b1;
      end
    endcase
  end

endmodule

// ===== hdl/elk_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module elk_sync import elk_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ==========================================================
  // one stage pair per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic hold_q;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          hold_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          hold_q <= meta_q;
        end
      end
      assign dout[i] = hold_q;
    end
  endgenerate

endmodule

// ===== hdl/elk_top.sv
// eprom lock, encryption verify and signature access top
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "elk_params.svh"
module elk_top import elk_pkg::*; #(
  parameter logic [7:0] SIG_BYTE0 = 8'ha5, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h3c // arbitrary value
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire elk_pgm_in_type PGM_IN,
  output logic [7:0] PGM_DATA_O,
  output logic PGM_DATA_OE,
  input wire logic EXTERNAL_ACCESS_PIN,
  input wire elk_cpu_req_type CPU_REQ,
  output elk_cpu_gnt_type CPU_GNT
);

  // ==========================================================
  // storage
  // nonvolatile contents start erased, locks unprogrammed
  logic [7:0] code_mem [0:`ELK_CODE_DEPTH-1] = '{default: `ELK_ERASED_BYTE};
  logic [7:0] enc_mem [0:`ELK_ENC_DEPTH-1] = '{default: `ELK_ERASED_BYTE};
  logic [2:0] lock_program_strobe_q = 3'h0;

  // ==========================================================
  // pin synchronisers
  elk_pgm_in_type pgm_s;
  logic ea_s;

  elk_sync #(.WIDTH($bits(elk_pgm_in_type) + 1)) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .din({PGM_IN, EXTERNAL_ACCESS_PIN}),
    .dout({pgm_s, ea_s})
  );

  // ==========================================================
  // mode decode
  function automatic elk_mode_type decode_mode(input logic [4:0] ctl);
    case (ctl)
      `ELK_CTL_PROGRAM_STROBE_CODE: decode_mode = MODE_PROGRAM_STROBE_CODE;
      `ELK_CTL_VERIFY: decode_mode = MODE_VERIFY;
      `ELK_CTL_PROGRAM_STROBE_ENC: decode_mode = MODE_PROGRAM_STROBE_ENC;
      `ELK_CTL_PROGRAM_STROBE_LB1: decode_mode = MODE_PROGRAM_STROBE_LB1;
      `ELK_CTL_PROGRAM_STROBE_LB2: decode_mode = MODE_PROGRAM_STROBE_LB2;
      `ELK_CTL_PROGRAM_STROBE_LB3: decode_mode = MODE_PROGRAM_STROBE_LB3;
      `ELK_CTL_SIGNATURE: decode_mode = MODE_SIGNATURE;
      default: decode_mode = MODE_IDLE;
    endcase
  endfunction

  logic [31:0] ctrl_q;
  logic erase_busy_q;
  logic [13:0] erase_addr_q;
  logic pins_en;
  logic in_pgm_mode;
  elk_mode_type mode;

  assign pins_en = ctrl_q[`ELK_CTRL_PINS_EN];
  assign in_pgm_mode = pins_en & pgm_s.program_strobe_rst & ~pgm_s.psen_n & ~erase_busy_q;
  assign mode = in_pgm_mode ? decode_mode(pgm_s.ctl) : MODE_IDLE;

  // ==========================================================
  // protection level captured once after reset
  elk_level_type level_now;
  elk_level_type level_q;
  logic undefined_now;
  logic [1:0] init_q;
  logic ea_latch_q;

  elk_level_dec u_dec (
    .lock_program_strobe(lock_program_strobe_q),
    .level(level_now),
    .undefined(undefined_now)
  );

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      init_q <= 2'h0;
      level_q <= LVL_NOEXT;
      ea_latch_q <= 1'b0;
    end else if (init_q != 2'h3) begin
      init_q <= init_q + 2'h1;
      // capture waits until the pin synchroniser holds real pin values
      if (init_q == 2'h2) begin
        level_q <= level_now;
        ea_latch_q <= ea_s;
      end
    end
  end

  // ==========================================================
  // program strobe pulses
  logic strobe_prev_q;
  logic pulse_end;
  logic array_write;
  logic refused;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= pgm_s.program_strobe_n;
    end
  end

  assign pulse_end = (init_q == 2'h3) & pgm_s.vpp_high & pgm_s.program_strobe_n & ~strobe_prev_q;
  assign array_write = pulse_end & ((mode == MODE_PROGRAM_STROBE_CODE) | (mode == MODE_PROGRAM_STROBE_ENC));
  assign refused = array_write & (level_q != LVL_NONE);

  // ==========================================================
  // nonvolatile array updates and erase sweep
  always_ff @(posedge CLK) begin
    if (erase_busy_q) begin
      code_mem[erase_addr_q] <= `ELK_ERASED_BYTE;
    end else if (array_write && !refused && mode == MODE_PROGRAM_STROBE_CODE) begin
      code_mem[pgm_s.addr] <= code_mem[pgm_s.addr] & pgm_s.data;
    end
  end

  always_ff @(posedge CLK) begin
    if (erase_busy_q) begin
      enc_mem[erase_addr_q[5:0]] <= `ELK_ERASED_BYTE;
      lock_program_strobe_q <= 3'h0;
    end else if (array_write && !refused && mode == MODE_PROGRAM_STROBE_ENC) begin
      enc_mem[pgm_s.addr[5:0]] <= enc_mem[pgm_s.addr[5:0]] & pgm_s.data;
    end else if (pulse_end) begin
      case (mode)
        MODE_PROGRAM_STROBE_LB1: lock_program_strobe_q[0] <= 1'b1;
        MODE_PROGRAM_STROBE_LB2: lock_program_strobe_q[1] <= 1'b1;
        MODE_PROGRAM_STROBE_LB3: lock_program_strobe_q[2] <= 1'b1;
        default: lock_program_strobe_q <= lock_program_strobe_q;
      endcase
    end
  end

  // ==========================================================
  // verify and signature read path
  logic [7:0] enc_byte;
  logic [7:0] code_byte;
  logic verify_blocked;

  assign code_byte = code_mem[pgm_s.addr];
  assign enc_byte = enc_mem[pgm_s.addr[5:0]];
  assign verify_blocked = (mode == MODE_VERIFY) & (level_q >= LVL_NOVERIFY);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PGM_DATA_O <= 8'h00;
      PGM_DATA_OE <= 1'b0;
    end else if (mode == MODE_VERIFY && !verify_blocked) begin
      PGM_DATA_O <= code_byte ~^ enc_byte;
      PGM_DATA_OE <= 1'b1;
    end else if (mode == MODE_SIGNATURE) begin
      PGM_DATA_OE <= 1'b1;
      case (pgm_s.addr)
        `ELK_SIG_LOC0: PGM_DATA_O <= SIG_BYTE0;
        `ELK_SIG_LOC1: PGM_DATA_O <= SIG_BYTE1;
        `ELK_SIG_LOC2: PGM_DATA_O <= SIG_BYTE2;
        default: PGM_DATA_O <= `ELK_ERASED_BYTE;
      endcase
    end else begin
      PGM_DATA_OE <= 1'b0;
    end
  end

  // ==========================================================
  // core fetch gating
  logic table_blocked;
  logic exec_blocked;

  assign table_blocked = CPU_REQ.table_read & CPU_REQ.from_external & (level_q != LVL_NONE);
  assign exec_blocked = CPU_REQ.ext_fetch & (level_q == LVL_NOEXT);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CPU_GNT <= '0;
    end else begin
      CPU_GNT.int_read_ok <= ~table_blocked;
      CPU_GNT.ext_exec_ok <= ~exec_blocked;
      CPU_GNT.external_access <= (level_q != LVL_NONE) ? ea_latch_q : ea_s;
    end
  end

  // ==========================================================
  // axi4-lite write channel
  logic [7:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] wr_mask;

  assign S_AXI_AWREADY = ~aw_held_q;
  assign S_AXI_WREADY = ~w_held_q;
  assign wr_fire = aw_held_q & w_held_q & ~S_AXI_BVALID;
  assign wr_ok = (aw_addr_q == `ELK_REG_CTRL) | (aw_addr_q == `ELK_REG_FLAGS) | (aw_addr_q == `ELK_REG_PULSES);
  assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (S_AXI_AWVALID && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (S_AXI_WVALID && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // control register and erase sweep
  logic ctrl_wr;
  logic erase_start;

  assign ctrl_wr = wr_fire & (aw_addr_q == `ELK_REG_CTRL);
  assign erase_start = ctrl_wr & w_strb_q[0] & w_data_q[`ELK_CTRL_ERASE] & ~erase_busy_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q <= `ELK_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ((ctrl_q & ~wr_mask) | (w_data_q & wr_mask)) & 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      erase_busy_q <= 1'b0;
      erase_addr_q <= 14'h0000;
    end else if (erase_start) begin
      erase_busy_q <= 1'b1;
      erase_addr_q <= 14'h0000;
    end else if (erase_busy_q) begin
      erase_addr_q <= erase_addr_q + 14'h0001;
      erase_busy_q <= (erase_addr_q != 14'h3fff);
    end
  end

  // ==========================================================
  // sticky event flags, set wins over clear
  logic [3:0] flags_q;
  logic [3:0] flags_set;
  logic [3:0] flags_clr;

  assign flags_set = {CPU_REQ.ext_fetch & exec_blocked, table_blocked, verify_blocked, refused};
  assign flags_clr = (wr_fire && aw_addr_q == `ELK_REG_FLAGS && w_strb_q[0]) ? w_data_q[3:0] : 4'h0;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  // ==========================================================
  // accepted strobe pulse counter, write clears
  logic [31:0] pulses_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pulses_q <= 32'h0000_0000;
    end else if (wr_fire && aw_addr_q == `ELK_REG_PULSES) begin
      pulses_q <= 32'h0000_0000;
    end else if (pulse_end && mode != MODE_IDLE && !refused) begin
      pulses_q <= pulses_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  logic [31:0] status_word;

  assign status_word = {23'h0, erase_busy_q, undefined_now, CPU_GNT.external_access, ea_latch_q,
                        lock_program_strobe_q, level_q};
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'h0;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'h0;
      case (S_AXI_ARADDR)
        `ELK_REG_CTRL: S_AXI_RDATA <= {30'h0, erase_busy_q, ctrl_q[0]};
        `ELK_REG_STATUS: S_AXI_RDATA <= status_word;
        `ELK_REG_FLAGS: S_AXI_RDATA <= {28'h0000000, flags_q};
        `ELK_REG_PULSES: S_AXI_RDATA <= pulses_q;
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= 2'h2;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// ===== shared/elk_params.svh
// constants for the eprom lock and signature access block
`ifndef ELK_PARAMS_SVH
`define ELK_PARAMS_SVH

// ==========================================================
// register map
`define ELK_REG_CTRL 8'h00
`define ELK_REG_STATUS 8'h04
`define ELK_REG_FLAGS 8'h08
`define ELK_REG_PULSES 8'h0c

// ==========================================================
// field positions
`define ELK_CTRL_PINS_EN 0
`define ELK_CTRL_ERASE 1
`define ELK_CTRL_RESET 32'h0000_0001
`define ELK_FLAG_REFUSED 0
`define ELK_FLAG_VERIFY_BLK 1
`define ELK_FLAG_TABLE_BLK 2
`define ELK_FLAG_EXEC_BLK 3

// ==========================================================
// array geometry and signature
`define ELK_ADDR_W 14
`define ELK_CODE_DEPTH 16384
`define ELK_ENC_DEPTH 64
`define ELK_SIG_LOC0 14'h0030
`define ELK_SIG_LOC1 14'h0031
`define ELK_SIG_LOC2 14'h0060
`define ELK_ERASED_BYTE 8'hff

// ==========================================================
// control line patterns: {ctl_a, ctl_b, ctl_c, ctl_d, ctl_e}
`define ELK_CTL_PROGRAM_STROBE_CODE 5'h0f
`define ELK_CTL_VERIFY 5'h03
`define ELK_CTL_PROGRAM_STROBE_ENC 5'h0d
`define ELK_CTL_PROGRAM_STROBE_LB1 5'h1f
`define ELK_CTL_PROGRAM_STROBE_LB2 5'h1c
`define ELK_CTL_PROGRAM_STROBE_LB3 5'h16
`define ELK_CTL_SIGNATURE 5'h00

// ==========================================================
// timing
`define ELK_CLK_PERIOD_NS 4
`define ELK_OSC_PERIOD_NS 4
`define ELK_VERIFY_MAX_PERIODS 48
`define ELK_VERIFY_MAX_CYC ((`ELK_VERIFY_MAX_PERIODS * `ELK_OSC_PERIOD_NS) / `ELK_CLK_PERIOD_NS)

`endif

// ===== shared/elk_pkg.sv
// types for the eprom lock and signature access block
package elk_pkg;

  // ==========================================================
  // protection level and mode
  typedef enum logic [1:0] {
    LVL_NONE,
    LVL_BASIC,
    LVL_NOVERIFY,
    LVL_NOEXT
  } elk_level_type;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_PROGRAM_STROBE_CODE,
    MODE_VERIFY,
    MODE_PROGRAM_STROBE_ENC,
    MODE_PROGRAM_STROBE_LB1,
    MODE_PROGRAM_STROBE_LB2,
    MODE_PROGRAM_STROBE_LB3,
    MODE_SIGNATURE
  } elk_mode_type;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] data;
    logic [4:0] ctl;
    logic program_strobe_rst;
    logic psen_n;
    logic vpp_high;
    logic program_strobe_n;
  } elk_pgm_in_type;

  typedef struct packed {
    logic table_read;
    logic from_external;
    logic ext_fetch;
  } elk_cpu_req_type;

  typedef struct packed {
    logic int_read_ok;
    logic ext_exec_ok;
    logic external_access;
  } elk_cpu_gnt_type;

endpackage
